/* File: shared/icsr_pkg.sv */
// Package for the interrupt control and status register block.
// Assumes a 16-bit register port with word indices chosen below.
package icsr_pkg;
   // ==========================================================
   // Register indices on the plain register port.
   localparam logic [3:0] ADDR_CORE_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_PROC_STATUS = 4'h1;
   localparam logic [3:0] ADDR_INTCTL_ONE = 4'h2;
   localparam logic [3:0] ADDR_INTCTL_TWO = 4'h3;
   localparam logic [3:0] ADDR_FLAGS_ZERO = 4'h4;
   localparam logic [3:0] ADDR_FLAGS_ONE = 4'h5;
   localparam logic [3:0] ADDR_FLAGS_TWO = 4'h6;
   localparam logic [3:0] ADDR_EVT_STATUS = 4'h7;
   localparam logic [3:0] ADDR_EVT_MASK = 4'h8;
   // ==========================================================
   // Field positions.
   localparam int CORE_PRIO_UPPER_POS = 3;
   localparam int CORE_PROG_VIS_POS = 2;
   localparam int STATUS_PRIO_LSB = 5;
   localparam int ICTL1_NEST_POS = 15;
   localparam int ICTL1_OSC_POS = 1;
   localparam int ICTL1_STACK_POS = 2;
   localparam int ICTL1_ADDR_POS = 3;
   localparam int ICTL1_ARITH_POS = 4;
   localparam int ICTL1_DMA_POS = 5;
   localparam int ICTL1_DIV0_POS = 6;
   localparam int ICTL2_ALT_POS = 15;
   localparam int ICTL2_INSTR_DIS_POS = 14;
   localparam logic [3:0] PRIO_UPPER_LIMIT = 4'h7;
   // ==========================================================
   // Implemented-bit masks and reset values.
   localparam logic [15:0] ICTL1_MASK = 16'h807e;
   localparam logic [15:0] ICTL2_MASK = 16'h801f;
   localparam logic [15:0] PSTAT_MASK = 16'h01ff;
   localparam logic [15:0] FLAGS0_MASK = 16'h7fff;
   localparam logic [15:0] FLAGS1_MASK = 16'hfffb;
   localparam logic [15:0] FLAGS2_MASK = 16'hdfff;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [2:0] EVT_MASK = 3'h7;
   // Event status bits: trap, flag request, external edge.
   localparam int EVT_TRAP_POS = 0;
   localparam int EVT_FLAG_POS = 1;
   localparam int EVT_EXT_POS = 2;

   typedef struct packed {
      logic div_zero;
      logic dma_ctrl;
      logic arith;
      logic addr;
      logic stack;
      logic osc_fail;
   } icsr_trap_s;

   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } icsr_bus_s;
endpackage

/* File: rtl/icsr_regs.sv */
// Interrupt control, trap status and interrupt flag registers.
// Assumes a same-clock register port and same-clock peripheral requests;
// the five external interrupt pins are asynchronous.
//
// Summary of operation
// - Upper priority bit reads one when priority level exceeds seven.
// - Priority level is upper bit above status bits seven to five.
// - Software writes cannot change the upper priority bit.
// - Nesting disable bit fifteen disables nesting; resets to zero.
// - Lower priority bits are read-only while nesting is disabled.
// - Trap flags set sticky: osc 1, stack 2, address 3, math 4, DMA 5.
// - Bit six set when the math trap came from divide by zero.
// - Bits fourteen to seven and zero of control one read zero.
// - Polarity bit one picks falling edge, zero rising, per input.
// - Alternate table select chooses the vector table used for fetch.
// - Flag bits set on request, zero otherwise; all reset to zero.
// - Each source except external pins three and four sets its own flag, kept until software clears it.
// - Flag register zero low byte maps the first eight sources.
// - Flag register zero high byte maps next seven; bit fifteen absent.
// - Flag register one low byte map, bit two absent.
// - Flag register one high byte map.
// - Flag register two map, bit thirteen absent.
`timescale 1ns/10ps
module icsr_regs (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Core side
   input wire logic core_prio_upper_set,
   input wire logic core_prio_upper_clr,
   input wire logic core_prio_wr,
   input wire logic [2:0] core_prio_wdata,
   input wire logic instr_disable_active,
   input wire icsr_pkg::icsr_trap_s trap_event,
   output logic [3:0] prio_level,
   output logic nesting_disable,
   output logic alt_table_select,
   output logic irq_pending,
   // Interrupt sources
   input wire logic [15:0] flags_zero_req,
   input wire logic [15:0] flags_one_req,
   input wire logic [15:0] flags_two_req,
   input wire logic [4:0] ext_irq_pin,
   // Event interrupt
   output logic irq_out
);
   // ==========================================================
   // Register port decode
   icsr_pkg::icsr_bus_s bus;
   assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   logic wr_core, wr_pstat, wr_ictl1, wr_ictl2, wr_f0, wr_f1, wr_f2, wr_evst, wr_evmk;
   assign wr_core = bus.wr && (bus.addr == icsr_pkg::ADDR_CORE_CONTROL);
   assign wr_pstat = bus.wr && (bus.addr == icsr_pkg::ADDR_PROC_STATUS);
   assign wr_ictl1 = bus.wr && (bus.addr == icsr_pkg::ADDR_INTCTL_ONE);
   assign wr_ictl2 = bus.wr && (bus.addr == icsr_pkg::ADDR_INTCTL_TWO);
   assign wr_f0 = bus.wr && (bus.addr == icsr_pkg::ADDR_FLAGS_ZERO);
   assign wr_f1 = bus.wr && (bus.addr == icsr_pkg::ADDR_FLAGS_ONE);
   assign wr_f2 = bus.wr && (bus.addr == icsr_pkg::ADDR_FLAGS_TWO);
   assign wr_evst = bus.wr && (bus.addr == icsr_pkg::ADDR_EVT_STATUS);
   assign wr_evmk = bus.wr && (bus.addr == icsr_pkg::ADDR_EVT_MASK);

   // ==========================================================
   // Core control: upper priority bit and data space visibility
   logic prio_upper_ff;
   logic prog_vis_ff;
   // The upper bit only moves on core trap entry and return, never by software.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         prio_upper_ff <= 1'b0;
      end else if (core_prio_upper_set) begin
         prio_upper_ff <= 1'b1;
      end else if (core_prio_upper_clr) begin
         prio_upper_ff <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         prog_vis_ff <= 1'b0;
      end else if (wr_core) begin
         prog_vis_ff <= bus.wdata[icsr_pkg::CORE_PROG_VIS_POS];
      end
   end

   // ==========================================================
   // Processor status: lower priority bits and the other status bits
   logic [8:0] pstat_ff;
   logic [15:0] pstat_next;
   always_comb begin
      pstat_next = {7'h00, pstat_ff};
      if (wr_pstat) begin
         pstat_next[4:0] = bus.wdata[4:0];
         pstat_next[8] = bus.wdata[8];
         if (!nesting_disable) begin
            pstat_next[7:5] = bus.wdata[7:5];
         end
      end
      // The core may always move its own level, e.g. on exception entry.
      if (core_prio_wr) begin
         pstat_next[7:5] = core_prio_wdata;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pstat_ff <= 9'h000;
      end else begin
         pstat_ff <= pstat_next[8:0];
      end
   end

   assign prio_level = {prio_upper_ff, pstat_ff[7:5]};

   // ==========================================================
   // Interrupt control one: nesting disable and sticky trap flags
   logic [15:0] ictl1_ff;
   logic [15:0] trap_set;
   always_comb begin
      trap_set = 16'h0000;
      trap_set[icsr_pkg::ICTL1_OSC_POS] = trap_event.osc_fail;
      trap_set[icsr_pkg::ICTL1_STACK_POS] = trap_event.stack;
      trap_set[icsr_pkg::ICTL1_ADDR_POS] = trap_event.addr;
      trap_set[icsr_pkg::ICTL1_ARITH_POS] = trap_event.arith;
      trap_set[icsr_pkg::ICTL1_DMA_POS] = trap_event.dma_ctrl;
      // Cause bit follows only a math trap.
      trap_set[icsr_pkg::ICTL1_DIV0_POS] = trap_event.arith && trap_event.div_zero;
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ictl1_ff <= icsr_pkg::REG_RESET;
      end else if (wr_ictl1) begin
         ictl1_ff <= (bus.wdata | trap_set) & icsr_pkg::ICTL1_MASK;
      end else begin
         ictl1_ff <= (ictl1_ff | trap_set) & icsr_pkg::ICTL1_MASK;
      end
   end

   assign nesting_disable = ictl1_ff[icsr_pkg::ICTL1_NEST_POS];

   // ==========================================================
   // Interrupt control two: vector table select and edge polarity
   logic alt_ff;
   logic [4:0] polarity_ff;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         alt_ff <= 1'b0;
         polarity_ff <= 5'h00;
      end else if (wr_ictl2) begin
         alt_ff <= bus.wdata[icsr_pkg::ICTL2_ALT_POS];
         polarity_ff <= bus.wdata[4:0];
      end
   end

   assign alt_table_select = alt_ff;

   // ==========================================================
   // External pins: synchroniser and edge select
   logic [4:0] ext_meta_ff, ext_sync_ff, ext_last_ff;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ext_meta_ff <= 5'h00;
         ext_sync_ff <= 5'h00;
         ext_last_ff <= 5'h00;
      end else begin
         ext_meta_ff <= ext_irq_pin;
         ext_sync_ff <= ext_meta_ff;
         ext_last_ff <= ext_sync_ff;
      end
   end

   // Edges count only once both compared stages hold real pin samples.
   // This keeps a pin that idles high from faking an edge after reset.
   logic [2:0] ext_prime_ff;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ext_prime_ff <= 3'h0;
      end else begin
         ext_prime_ff <= {ext_prime_ff[1:0], 1'b1};
      end
   end

   logic [4:0] ext_edge;
   // Polarity one picks the falling edge, zero the rising edge.
   assign ext_edge = {5{ext_prime_ff[2]}}
                   & ((polarity_ff & ext_last_ff & ~ext_sync_ff)
                   | (~polarity_ff & ~ext_last_ff & ext_sync_ff));

   // ==========================================================
   // Interrupt flag registers
   logic [15:0] set_f0, set_f1, set_f2;
   always_comb begin
      set_f0 = flags_zero_req;
      set_f0[0] = ext_edge[0];
      set_f1 = flags_one_req;
      set_f1[4] = ext_edge[1];
      set_f1[13] = ext_edge[2];
      set_f2 = flags_two_req;
   end

   logic [15:0] flags0_ff, flags1_ff, flags2_ff;
   // Software may write either value; a same-cycle request still wins.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         flags0_ff <= icsr_pkg::REG_RESET;
         flags1_ff <= icsr_pkg::REG_RESET;
         flags2_ff <= icsr_pkg::REG_RESET;
      end else begin
         flags0_ff <= ((wr_f0 ? bus.wdata : flags0_ff) | set_f0) & icsr_pkg::FLAGS0_MASK;
         flags1_ff <= ((wr_f1 ? bus.wdata : flags1_ff) | set_f1) & icsr_pkg::FLAGS1_MASK;
         flags2_ff <= ((wr_f2 ? bus.wdata : flags2_ff) | set_f2) & icsr_pkg::FLAGS2_MASK;
      end
   end

   // Servicing never clears a flag; only the register write does.
   assign irq_pending = |{flags0_ff, flags1_ff, flags2_ff};

   // ==========================================================
   // Event status, mask and interrupt output
   logic [2:0] evt_status_ff, evt_mask_ff, evt_set;
   assign evt_set[icsr_pkg::EVT_TRAP_POS] = |trap_set;
   assign evt_set[icsr_pkg::EVT_FLAG_POS] = |{set_f0, set_f1, set_f2};
   assign evt_set[icsr_pkg::EVT_EXT_POS] = |ext_edge;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         evt_status_ff <= 3'h0;
      end else if (wr_evst) begin
         evt_status_ff <= (evt_status_ff & ~bus.wdata[2:0]) | evt_set;
      end else begin
         evt_status_ff <= evt_status_ff | evt_set;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         evt_mask_ff <= 3'h0;
      end else if (wr_evmk) begin
         evt_mask_ff <= bus.wdata[2:0] & icsr_pkg::EVT_MASK;
      end
   end

   assign irq_out = |(evt_status_ff & evt_mask_ff);

   // ==========================================================
   // Read data, one cycle after the read strobe
   logic [15:0] rd_mux;
   always_comb begin
      rd_mux = 16'h0000;
      unique case (bus.addr)
         icsr_pkg::ADDR_CORE_CONTROL: begin
            rd_mux[icsr_pkg::CORE_PRIO_UPPER_POS] =
               (prio_level > icsr_pkg::PRIO_UPPER_LIMIT);
            rd_mux[icsr_pkg::CORE_PROG_VIS_POS] = prog_vis_ff;
         end
         icsr_pkg::ADDR_PROC_STATUS: rd_mux = {7'h00, pstat_ff} & icsr_pkg::PSTAT_MASK;
         icsr_pkg::ADDR_INTCTL_ONE: rd_mux = ictl1_ff;
         icsr_pkg::ADDR_INTCTL_TWO: begin
            rd_mux[icsr_pkg::ICTL2_ALT_POS] = alt_ff;
            rd_mux[icsr_pkg::ICTL2_INSTR_DIS_POS] = instr_disable_active;
            rd_mux[4:0] = polarity_ff;
         end
         icsr_pkg::ADDR_FLAGS_ZERO: rd_mux = flags0_ff;
         icsr_pkg::ADDR_FLAGS_ONE: rd_mux = flags1_ff;
         icsr_pkg::ADDR_FLAGS_TWO: rd_mux = flags2_ff;
         icsr_pkg::ADDR_EVT_STATUS: rd_mux[2:0] = evt_status_ff;
         icsr_pkg::ADDR_EVT_MASK: rd_mux[2:0] = evt_mask_ff;
         default: rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 16'h0000;
      end else if (bus.rd) begin
         reg_rdata <= rd_mux;
      end else begin
         reg_rdata <= 16'h0000;
      end
   end
endmodule // icsr_regs

/* File: test/icsr_regs_properties.sv */
// Concurrent checks for the interrupt control register block.
// Bound to icsr_regs from the bench; sees only that module's ports.
`timescale 1ns/10ps
module icsr_regs_checker (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   // Core side and flags
   input wire logic core_prio_upper_set,
   input wire logic core_prio_upper_clr,
   input wire logic core_prio_wr,
   input wire logic [3:0] prio_level,
   input wire logic nesting_disable,
   input wire logic alt_table_select,
   input wire logic irq_pending,
   input wire logic [15:0] flags_zero_req
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   // ==========================================================
   // Assertions
   upper_read_a: assert property (
      $past(reg_rd && reg_addr == 4'h0) |-> reg_rdata[3] == ($past(prio_level) > 4'h7))
      else $error("upper priority bit reads wrong");
   low_prio_read_a: assert property (
      $past(reg_rd && reg_addr == 4'h1) |-> reg_rdata[7:5] == $past(prio_level[2:0]))
      else $error("priority level low bits differ from status");
   upper_locked_a: assert property (
      reg_wr && reg_addr == 4'h0 && !core_prio_upper_set && !core_prio_upper_clr
      |=> prio_level[3] == $past(prio_level[3])) else $error("software changed upper bit");
   nest_write_a: assert property (
      reg_wr && reg_addr == 4'h2 |=> nesting_disable == $past(reg_wdata[15]))
      else $error("nesting disable not written");
   low_prio_frozen_a: assert property (
      nesting_disable && reg_wr && reg_addr == 4'h1 && !core_prio_wr |=> $stable(prio_level[2:0]))
      else $error("priority bits written while nesting disabled");
   ctl_one_zero_a: assert property (
      $past(reg_rd && reg_addr == 4'h2) |-> reg_rdata[14:7] == 8'h00 && !reg_rdata[0])
      else $error("unimplemented control bits not zero");
   alt_write_a: assert property (
      reg_wr && reg_addr == 4'h3 |=> alt_table_select == $past(reg_wdata[15]))
      else $error("table select not written");
   flag_pending_a: assert property (
      flags_zero_req[3] |=> irq_pending) else $error("request did not raise pending");
endmodule // icsr_regs_checker

/* File: test/icsr_core_model.sv */
// Model of the processor core and the interrupt sources.
// Tasks are called by the bench; outputs change right after a rising edge.
`timescale 1ns/10ps
module icsr_core_model (
   // Clock
   input wire logic clock,
   // Core side
   output logic core_prio_upper_set,
   output logic core_prio_upper_clr,
   output logic core_prio_wr,
   output logic [2:0] core_prio_wdata,
   output logic instr_disable_active,
   output icsr_pkg::icsr_trap_s trap_event,
   // Interrupt sources
   output logic [15:0] flags_zero_req,
   output logic [15:0] flags_one_req,
   output logic [15:0] flags_two_req,
   output logic [4:0] ext_irq_pin
);
   initial begin
      {core_prio_upper_set, core_prio_upper_clr, core_prio_wr, core_prio_wdata} = 6'h00;
      {instr_disable_active, trap_event, ext_irq_pin} = 12'h000;
      {flags_zero_req, flags_one_req, flags_two_req} = 48'h0;
   end
   // Each source pulses its own request bit for one cycle.
   task automatic pulse_flag(input int r, input int b);
      @(posedge clock);
      flags_zero_req <= (r == 0) ? 16'h0001 << b : 16'h0000;
      flags_one_req <= (r == 1) ? 16'h0001 << b : 16'h0000;
      flags_two_req <= (r == 2) ? 16'h0001 << b : 16'h0000;
      @(posedge clock);
      {flags_zero_req, flags_one_req, flags_two_req} <= 48'h0;
      #1;
   endtask
   task automatic pulse_trap(input logic [5:0] t);
      @(posedge clock);
      trap_event <= t;
      @(posedge clock);
      trap_event <= 6'h00;
      #1;
   endtask
   task automatic core(input logic s, input logic c, input logic w, input logic [2:0] v);
      @(posedge clock);
      {core_prio_upper_set, core_prio_upper_clr, core_prio_wr, core_prio_wdata} <= {s, c, w, v};
      @(posedge clock);
      {core_prio_upper_set, core_prio_upper_clr, core_prio_wr} <= 3'h0;
      #1;
   endtask
   task automatic levels(input logic [4:0] pins, input logic dis);
      @(posedge clock);
      ext_irq_pin <= pins;
      instr_disable_active <= dis;
      #1;
   endtask
endmodule // icsr_core_model

/* File: test/test_icsr_regs.sv */
// Self-checking bench for the interrupt control register block.
// Needs the package, design, core model and checker compiled first.
`timescale 1ns/10ps
module test_icsr_regs;
   typedef struct packed {logic [3:0] a; logic [15:0] d; logic [15:0] e;} icsr_row_s;
   // Write the data, then read back the expected value.
   icsr_row_s rows [16] = '{'{4'h0, 16'hffff, 16'h0004}, '{4'h1, 16'hffff, 16'h01ff},
      '{4'h1, 16'h0000, 16'h0000}, '{4'h2, 16'hffff, 16'h807e}, '{4'h2, 16'h0000, 16'h0000},
      '{4'h3, 16'hffff, 16'h801f}, '{4'h3, 16'h0000, 16'h0000}, '{4'h4, 16'hffff, 16'h7fff},
      '{4'h4, 16'h0000, 16'h0000}, '{4'h5, 16'hffff, 16'hfffb}, '{4'h5, 16'h0000, 16'h0000},
      '{4'h6, 16'hffff, 16'hdfff}, '{4'h6, 16'h0000, 16'h0000}, '{4'hf, 16'hffff, 16'h0000},
      '{4'h8, 16'hffff, 16'h0007}, '{4'h8, 16'h0000, 16'h0000}};
   // Flag bits fed by request inputs; pin-fed flags are left out.
   logic [15:0] src_bits [3] = '{16'h7ffe, 16'hdfeb, 16'hdfff};
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata, flags_zero_req, flags_one_req, flags_two_req;
   logic core_prio_upper_set, core_prio_upper_clr, core_prio_wr, instr_disable_active;
   logic [2:0] core_prio_wdata;
   icsr_pkg::icsr_trap_s trap_event;
   logic [4:0] ext_irq_pin;
   logic [3:0] prio_level;
   logic nesting_disable, alt_table_select, irq_pending, irq_out;
   int fail_count = 0;
   int checks = 0;
   always #2.5 clock = ~clock;
   icsr_regs icsr_regs_i (.clock, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .core_prio_upper_set, .core_prio_upper_clr, .core_prio_wr, .core_prio_wdata,
      .instr_disable_active, .trap_event, .prio_level, .nesting_disable, .alt_table_select,
      .irq_pending, .flags_zero_req, .flags_one_req, .flags_two_req, .ext_irq_pin, .irq_out);
   icsr_core_model icsr_core_model_i (.clock, .core_prio_upper_set, .core_prio_upper_clr,
      .core_prio_wr, .core_prio_wdata, .instr_disable_active, .trap_event, .flags_zero_req,
      .flags_one_req, .flags_two_req, .ext_irq_pin);
   // ==========================================================
   // Checks and bus tasks
   task automatic check(input logic [15:0] got, input logic [15:0] e);
      checks++;
      if (got !== e) begin
         fail_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, e);
      end
   endtask
   task automatic check_bit(input logic got, input logic e);
      check({15'h0000, got}, {15'h0000, e});
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clock);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m = 16'hffff);
      @(posedge clock);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 check(reg_rdata & m, e);
   endtask
   task automatic close_out();
      if (fail_count == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #100000;
      fail_count++;
      close_out();
   end
   // ==========================================================
   // Test sequence
   initial begin
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      for (int a = 0; a < 9; a++) rd(4'(a), 16'h0000);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      for (int r = 0; r < 3; r++) begin
         for (int b = 0; b < 16; b++) begin
            if (src_bits[r][b]) begin
               icsr_core_model_i.pulse_flag(r, b);
               rd(4'(4 + r), 16'h0001 << b);
               check_bit(irq_pending, 1'b1);
               wr(4'(4 + r), 16'h0000);
               check_bit(irq_pending, 1'b0);
            end
         end
      end
      wr(4'h7, 16'h0007);
      for (int i = 0; i < 5; i++) begin
         wr(4'h3, 16'h0001 << i);
         icsr_core_model_i.levels(5'h01 << i, 1'b0);
         repeat (5) @(posedge clock);
         rd(4'h7, 16'h0000, 16'h0004);
         icsr_core_model_i.levels(5'h00, 1'b0);
         repeat (5) @(posedge clock);
         rd(4'h7, 16'h0004, 16'h0004);
         wr(4'h3, 16'h0000);
         wr(4'h7, 16'h0007);
         icsr_core_model_i.levels(5'h01 << i, 1'b0);
         repeat (5) @(posedge clock);
         rd(4'h7, 16'h0004, 16'h0004);
         icsr_core_model_i.levels(5'h00, 1'b0);
         wr(4'h7, 16'h0007);
      end
      rd(4'h4, 16'h0001, 16'h0001);
      rd(4'h5, 16'h2010, 16'h2010);
      wr(4'h4, 16'h0000);
      wr(4'h5, 16'h0000);
      wr(4'h7, 16'h0007);
      wr(4'h8, 16'h0001);
      for (int t = 0; t < 5; t++) begin
         icsr_core_model_i.pulse_trap(6'h01 << t);
         check_bit(irq_out, 1'b1);
         rd(4'h2, 16'h0002 << t);
         wr(4'h2, 16'h0000);
         wr(4'h7, 16'h0001);
         check_bit(irq_out, 1'b0);
      end
      icsr_core_model_i.pulse_trap(6'h28);
      rd(4'h2, 16'h0050);
      wr(4'h8, 16'h0000);
      check_bit(irq_out, 1'b0);
      wr(4'h8, 16'h0001);
      check_bit(irq_out, 1'b1);
      wr(4'h2, 16'h0000);
      icsr_core_model_i.core(1'b1, 1'b0, 1'b0, 3'h0);
      check({12'h000, prio_level}, 16'h0008);
      wr(4'h0, 16'h0000);
      rd(4'h0, 16'h0008, 16'h0008);
      icsr_core_model_i.core(1'b0, 1'b1, 1'b0, 3'h0);
      wr(4'h2, 16'h8000);
      check_bit(nesting_disable, 1'b1);
      wr(4'h1, 16'h00e0);
      rd(4'h1, 16'h0000, 16'h00e0);
      icsr_core_model_i.core(1'b0, 1'b0, 1'b1, 3'h5);
      check({12'h000, prio_level}, 16'h0005);
      wr(4'h2, 16'h0000);
      wr(4'h1, 16'h0060);
      check({12'h000, prio_level}, 16'h0003);
      icsr_core_model_i.levels(5'h00, 1'b1);
      rd(4'h3, 16'h4000, 16'h4000);
      @(posedge clock);
      reset_n <= 1'b0;
      #1 check({12'h000, prio_level}, 16'h0000);
      check_bit(irq_out, 1'b0);
      @(posedge clock);
      reset_n <= 1'b1;
      rd(4'h2, 16'h0000);
      rd(4'h1, 16'h0000);
      close_out();
   end
endmodule // test_icsr_regs
bind icsr_regs icsr_regs_checker icsr_regs_checker_i (.clock, .reset_n, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .core_prio_upper_set, .core_prio_upper_clr, .core_prio_wr,
   .prio_level, .nesting_disable, .alt_table_select, .irq_pending, .flags_zero_req);
